/* File: design/dcf_fifo.sv */
// dual clock buffer with full, empty, threshold and handshake flags
`timescale 1ns/1ps

module dcf_fifo
	import dcf_pkg::*;
#(
	parameter int           PUSH_WIDTH     = 32,
	parameter int           POP_WIDTH      = 32,
	parameter int           PUSH_ADDR_BITS = 4,
	parameter bit           DUAL_CLK       = 1'b1,
	parameter bit           FWFT_EN        = 1'b0,
	parameter dcf_th_mode_t HI_MODE        = DCF_TH_CONST,
	parameter dcf_th_mode_t LO_MODE        = DCF_TH_CONST,
	parameter int           HI_THRESH      = 12,
	parameter int           HI_ASSERT      = 12,
	parameter int           HI_NEGATE      = 10,
	parameter int           LO_THRESH      = 3,
	parameter int           LO_ASSERT      = 3,
	parameter int           LO_NEGATE      = 5,
	// derived: pop address width so both sides cover the same store
	parameter int           POP_ADDR_BITS  = PUSH_ADDR_BITS
		+ $clog2(PUSH_WIDTH) - $clog2(POP_WIDTH)
)
(
	// push clock domain, also the register bus clock
	input  wire logic                        clk_sys_i,
	input  wire logic                        srst_i,
	input  wire logic                        push_rst_n_i,
	// pop clock domain
	input  wire logic                        pop_clk_i,
	input  wire logic                        pop_rst_n_i,
	// push side
	input  wire logic [PUSH_WIDTH-1:0]       push_data_i,
	input  wire logic                        push_i,
	input  wire logic                        push_clr_i,
	input  wire logic [PUSH_ADDR_BITS-1:0]   hi_thresh_i,
	input  wire logic [PUSH_ADDR_BITS-1:0]   hi_assert_i,
	input  wire logic [PUSH_ADDR_BITS-1:0]   hi_negate_i,
	output logic                             full_o,
	output logic                             almost_full_o,
	output logic                             prog_full_o,
	output logic                             push_ack_o,
	output logic                             overflow_o,
	output logic [PUSH_ADDR_BITS-1:0]        push_count_o,
	// pop side
	input  wire logic                        pop_i,
	input  wire logic                        pop_clr_i,
	input  wire logic [POP_ADDR_BITS-1:0]    lo_thresh_i,
	input  wire logic [POP_ADDR_BITS-1:0]    lo_assert_i,
	input  wire logic [POP_ADDR_BITS-1:0]    lo_negate_i,
	output logic [POP_WIDTH-1:0]             pop_data_o,
	output logic                             empty_o,
	output logic                             almost_empty_o,
	output logic                             prog_empty_o,
	output logic                             pop_ack_o,
	output logic                             underflow_o,
	output logic [POP_ADDR_BITS-1:0]         pop_count_o,
	// avalon-mm slave
	input  wire logic [3:0]                  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	output logic [31:0]                      avs_readdata,
	output logic                             avs_waitrequest
);

	// ***************************************************************
	// geometry: store kept in units of the narrower width
	// ***************************************************************
	localparam int UNIT = (PUSH_WIDTH < POP_WIDTH) ? PUSH_WIDTH : POP_WIDTH;
	localparam int RW   = PUSH_WIDTH / UNIT;
	localparam int RR   = POP_WIDTH / UNIT;
	localparam int LRW  = $clog2(RW);
	localparam int LRR  = $clog2(RR);
	localparam int CAPU = RW << PUSH_ADDR_BITS;
	localparam int UB   = PUSH_ADDR_BITS + 1 + LRW;
	localparam int PA   = PUSH_ADDR_BITS;
	localparam int QA   = POP_ADDR_BITS;
	localparam logic [UB-1:0] CAP_U = UB'(CAPU);
	localparam logic [UB-1:0] RW_U  = UB'(RW);
	localparam logic [UB-1:0] RR_U  = UB'(RR);
	localparam logic [PA:0]   HI_T  = (PA+1)'(HI_THRESH);
	localparam logic [PA:0]   HI_A  = (PA+1)'(HI_ASSERT);
	localparam logic [PA:0]   HI_N  = (PA+1)'(HI_NEGATE);
	localparam logic [QA:0]   LO_T  = (QA+1)'(LO_THRESH);
	localparam logic [QA:0]   LO_A  = (QA+1)'(LO_ASSERT);
	localparam logic [QA:0]   LO_N  = (QA+1)'(LO_NEGATE);

	function automatic logic [PA:0] g2b_push(input logic [PA:0] g);
		logic [PA:0] b;
		b[PA] = g[PA];
		for (int i = PA - 1; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	function automatic logic [QA:0] g2b_pop(input logic [QA:0] g);
		logic [QA:0] b;
		b[QA] = g[QA];
		for (int i = QA - 1; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	// two-port store, one array of narrow units
	logic [UNIT-1:0] mem [CAPU];

	// ***************************************************************
	// push domain
	// ***************************************************************
	logic [PA:0]        wbin_reg, wbin_next, wgray_reg, wgray_next;
	logic [QA:0]        rsync1_reg, rsync2_reg, rbin_seen;
	logic               full_reg, full_next, afull_reg, afull_next;
	logic               pfull_reg, pfull_next, wack_reg, wack_next, ovf_reg, ovf_next;
	logic [PA-1:0]      wcnt_reg, wcnt_next;
	logic [UB-1:0]      wlvl;
	logic [PA:0]        wwords, hi_a, hi_n;
	logic               push_ok, pclr;
	logic [1:0]         ctrl_reg, ctrl_next;
	logic [QA:0]        rgray_reg, rbin_reg;

	assign pclr    = push_clr_i | ctrl_reg[DCF_CTRL_PCLR];
	assign push_ok = push_i & ~full_reg;

	always_comb
	begin
		unique case (HI_MODE)
			DCF_TH_CONST:      begin hi_a = HI_T; hi_n = HI_T; end
			DCF_TH_DYN_SINGLE: begin hi_a = {1'b0, hi_thresh_i}; hi_n = {1'b0, hi_thresh_i}; end
			DCF_TH_RANGE:      begin hi_a = HI_A; hi_n = HI_N; end
			DCF_TH_DYN_RANGE:  begin hi_a = {1'b0, hi_assert_i}; hi_n = {1'b0, hi_negate_i}; end
		endcase
	end

	always_comb
	begin
		wbin_next  = push_ok ? wbin_reg + 1'b1 : wbin_reg;
		wlvl       = (UB'(wbin_next) << LRW) - (UB'(rbin_seen) << LRR);
		wwords     = (PA+1)'(wlvl >> LRW);
		full_next  = (CAP_U - wlvl) < RW_U;
		afull_next = ~full_next && ((CAP_U - wlvl) < (RW_U << 1));
		if (wwords >= hi_a)
			pfull_next = 1'b1;
		else if (wwords < hi_n)
			pfull_next = 1'b0;
		else
			pfull_next = pfull_reg;
		wcnt_next  = wwords[PA-1:0];
		wack_next  = push_ok;
		ovf_next   = push_i & full_reg;
		wgray_next = wbin_next ^ (wbin_next >> 1);
		if (pclr)
		begin
			wbin_next  = '0;
			wgray_next = '0;
			full_next  = 1'b0;
			afull_next = 1'b0;
			pfull_next = 1'b0;
			wcnt_next  = '0;
			wack_next  = 1'b0;
			ovf_next   = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!push_rst_n_i)
		begin
			wbin_reg  <= '0;
			wgray_reg <= '0;
			full_reg  <= 1'b0;
			afull_reg <= 1'b0;
			pfull_reg <= 1'b0;
			wcnt_reg  <= '0;
			wack_reg  <= 1'b0;
			ovf_reg   <= 1'b0;
		end
		else
		begin
			wbin_reg  <= wbin_next;
			wgray_reg <= wgray_next;
			full_reg  <= full_next;
			afull_reg <= afull_next;
			pfull_reg <= pfull_next;
			wcnt_reg  <= wcnt_next;
			wack_reg  <= wack_next;
			ovf_reg   <= ovf_next;
		end
	end

	// refused pushes never reach the store
	always_ff @(posedge clk_sys_i)
	begin
		if (push_ok)
			for (int i = 0; i < RW; i++)
				mem[(UB-1)'((UB-1)'(wbin_reg[PA-1:0]) << LRW) + (UB-1)'(i)] <=
					push_data_i[i*UNIT +: UNIT];
	end

	// ***************************************************************
	// pointer crossing
	// ***************************************************************
	logic [PA:0] wsync1_reg, wsync2_reg, wbin_seen;

	generate
		if (DUAL_CLK)
		begin : g_dual
			always_ff @(posedge clk_sys_i)
			begin
				if (!push_rst_n_i)
				begin
					rsync1_reg <= '0;
					rsync2_reg <= '0;
				end
				else
				begin
					rsync1_reg <= rgray_reg;
					rsync2_reg <= rsync1_reg;
				end
			end
			always_ff @(posedge pop_clk_i)
			begin
				if (!pop_rst_n_i)
				begin
					wsync1_reg <= '0;
					wsync2_reg <= '0;
				end
				else
				begin
					wsync1_reg <= wgray_reg;
					wsync2_reg <= wsync1_reg;
				end
			end
			assign rbin_seen = g2b_pop(rsync2_reg);
			assign wbin_seen = g2b_push(wsync2_reg);
		end
		else
		begin : g_single
			// same clock: binary pointers read straight across
			assign rsync1_reg = '0;
			assign rsync2_reg = '0;
			assign wsync1_reg = '0;
			assign wsync2_reg = '0;
			assign rbin_seen  = rbin_reg;
			assign wbin_seen  = wbin_reg;
		end
	endgenerate

	// ***************************************************************
	// pop domain
	// ***************************************************************
	logic               empty_reg, empty_next, aempty_reg, aempty_next;
	logic               pempty_reg, pempty_next, rack_reg, rack_next, unf_reg, unf_next;
	logic               valid_reg, valid_next, fetch, pop_ok;
	logic [QA:0]        rbin_next, rgray_next, rwords, lo_a, lo_n;
	logic [QA-1:0]      rcnt_reg, rcnt_next;
	logic [UB-1:0]      rlvl_now, rlvl;
	logic [POP_WIDTH-1:0] rdata_reg, rdata_next, mem_word;

	assign pop_ok   = pop_i & ~empty_reg;
	assign rlvl_now = (UB'(wbin_seen) << LRW) - (UB'(rbin_reg) << LRR);

	always_comb
	begin
		for (int i = 0; i < RR; i++)
			mem_word[i*UNIT +: UNIT] =
				mem[(UB-1)'((UB-1)'(rbin_reg[QA-1:0]) << LRR) + (UB-1)'(i)];
	end

	always_comb
	begin
		unique case (LO_MODE)
			DCF_TH_CONST:      begin lo_a = LO_T; lo_n = LO_T; end
			DCF_TH_DYN_SINGLE: begin lo_a = {1'b0, lo_thresh_i}; lo_n = {1'b0, lo_thresh_i}; end
			DCF_TH_RANGE:      begin lo_a = LO_A; lo_n = LO_N; end
			DCF_TH_DYN_RANGE:  begin lo_a = {1'b0, lo_assert_i}; lo_n = {1'b0, lo_negate_i}; end
		endcase
	end

	always_comb
	begin
		// fall-through keeps one word parked on the output
		fetch      = FWFT_EN ? (rlvl_now >= RR_U) && (~valid_reg | pop_ok) : pop_ok;
		valid_next = FWFT_EN ? fetch | (valid_reg & ~pop_ok) : 1'b0;
		rbin_next  = fetch ? rbin_reg + 1'b1 : rbin_reg;
		rdata_next = fetch ? mem_word : rdata_reg;
		rlvl       = (UB'(wbin_seen) << LRW) - (UB'(rbin_next) << LRR);
		rwords     = (QA+1)'(rlvl >> LRR) + (QA+1)'(valid_next);
		empty_next = FWFT_EN ? ~valid_next : (rlvl < RR_U);
		aempty_next = rwords == (QA+1)'(1);
		if (rwords <= lo_a)
			pempty_next = 1'b1;
		else if (rwords > lo_n)
			pempty_next = 1'b0;
		else
			pempty_next = pempty_reg;
		rcnt_next  = rwords[QA-1:0];
		rack_next  = pop_ok;
		unf_next   = pop_i & empty_reg;
		rgray_next = rbin_next ^ (rbin_next >> 1);
		if (pop_clr_i | ctrl_reg[DCF_CTRL_QCLR])
		begin
			rbin_next   = '0;
			rgray_next  = '0;
			valid_next  = 1'b0;
			empty_next  = 1'b1;
			aempty_next = 1'b0;
			pempty_next = 1'b1;
			rcnt_next   = '0;
			rack_next   = 1'b0;
			unf_next    = 1'b0;
		end
	end

	always_ff @(posedge pop_clk_i)
	begin
		if (!pop_rst_n_i)
		begin
			rbin_reg   <= '0;
			rgray_reg  <= '0;
			valid_reg  <= 1'b0;
			empty_reg  <= 1'b1;
			aempty_reg <= 1'b0;
			pempty_reg <= 1'b1;
			rcnt_reg   <= '0;
			rack_reg   <= 1'b0;
			unf_reg    <= 1'b0;
			rdata_reg  <= '0;
		end
		else
		begin
			rbin_reg   <= rbin_next;
			rgray_reg  <= rgray_next;
			valid_reg  <= valid_next;
			empty_reg  <= empty_next;
			aempty_reg <= aempty_next;
			pempty_reg <= pempty_next;
			rcnt_reg   <= rcnt_next;
			rack_reg   <= rack_next;
			unf_reg    <= unf_next;
			rdata_reg  <= rdata_next;
		end
	end

	// ***************************************************************
	// avalon-mm slave, push clock
	// ***************************************************************
	logic [31:0] rdata_bus_reg, rdata_bus_next;
	logic        wait_reg, wait_next;

	always_comb
	begin
		// hold one wait cycle, then answer; commit on the released edge
		wait_next      = ~((avs_read | avs_write) & wait_reg);
		rdata_bus_next = rdata_bus_reg;
		ctrl_next      = ctrl_reg;
		if (avs_read & wait_reg)
		begin
			rdata_bus_next = DCF_RDATA_RST;
			if (avs_address == DCF_OFS_CTRL)
				rdata_bus_next[1:0] = ctrl_reg;
			else if (avs_address == DCF_OFS_STAT)
			begin
				rdata_bus_next[DCF_STAT_FULL]  = full_reg;
				rdata_bus_next[DCF_STAT_AFULL] = afull_reg;
				rdata_bus_next[DCF_STAT_PFULL] = pfull_reg;
				rdata_bus_next[DCF_STAT_CNT +: PA] = wcnt_reg;
			end
		end
		if (avs_write & ~wait_reg & (avs_address == DCF_OFS_CTRL))
			ctrl_next = avs_writedata[1:0];
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			wait_reg      <= 1'b1;
			rdata_bus_reg <= DCF_RDATA_RST;
			ctrl_reg      <= DCF_CTRL_RST;
		end
		else
		begin
			wait_reg      <= wait_next;
			rdata_bus_reg <= rdata_bus_next;
			ctrl_reg      <= ctrl_next;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign full_o          = full_reg;
	assign almost_full_o   = afull_reg;
	assign prog_full_o     = pfull_reg;
	assign push_ack_o      = wack_reg;
	assign overflow_o      = ovf_reg;
	assign push_count_o    = wcnt_reg;
	assign pop_data_o      = rdata_reg;
	assign empty_o         = empty_reg;
	assign almost_empty_o  = aempty_reg;
	assign prog_empty_o    = pempty_reg;
	assign pop_ack_o       = rack_reg;
	assign underflow_o     = unf_reg;
	assign pop_count_o     = rcnt_reg;
	assign avs_readdata    = rdata_bus_reg;
	assign avs_waitrequest = wait_reg;

	// ***************************************************************
	// checks
	// ***************************************************************
	refused_push_a: assert property (@(posedge clk_sys_i) disable iff (!push_rst_n_i)
		(push_i && full_reg && !pclr) |=> (wbin_reg == $past(wbin_reg)))
		else $error("refused push moved the push pointer");
	overflow_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!push_rst_n_i)
		(push_i && full_reg && !pclr) |=> overflow_o && !push_ack_o)
		else $error("overflow missing after refused push");
	push_ack_a: assert property (@(posedge clk_sys_i) disable iff (!push_rst_n_i)
		(push_i && !full_reg && !pclr) |=> push_ack_o && !overflow_o)
		else $error("push acknowledge missing");
	push_clear_a: assert property (@(posedge clk_sys_i) disable iff (!push_rst_n_i)
		push_clr_i |=> (wbin_reg == '0) && !full_o && !prog_full_o && push_count_o == '0)
		else $error("push clear left state behind");
	gray_step_a: assert property (@(posedge clk_sys_i) disable iff (!push_rst_n_i)
		!$past(pclr) |-> $countones(wgray_reg ^ $past(wgray_reg)) <= 1)
		else $error("push gray pointer changed more than one bit");
	underflow_pulse_a: assert property (@(posedge pop_clk_i) disable iff (!pop_rst_n_i)
		(pop_i && empty_reg && !pop_clr_i && !ctrl_reg[DCF_CTRL_QCLR]) |=> underflow_o)
		else $error("underflow missing after refused pop");
	pop_ack_a: assert property (@(posedge pop_clk_i) disable iff (!pop_rst_n_i)
		(pop_i && !empty_reg && !pop_clr_i && !ctrl_reg[DCF_CTRL_QCLR]) |=> pop_ack_o)
		else $error("pop acknowledge missing");
	empty_count_a: assert property (@(posedge pop_clk_i) disable iff (!pop_rst_n_i)
		almost_empty_o |-> !empty_o && pop_count_o == QA'(1))
		else $error("near-empty without one word");
	full_afull_a: assert property (@(posedge clk_sys_i) disable iff (!push_rst_n_i)
		!(full_o && almost_full_o))
		else $error("full and near-full together");

endmodule : dcf_fifo

/* File: design/dcf_pkg.sv */
// package: constants and types of the dual clock buffer with flags
// ***************************************************************
// Overview of operation
// - widths up to 128 bits, depth up to 1K, push and pop widths independent
// - push words of push width in, pop words of pop width out
// - words kept in a two-port store, written on push clock, read on pop clock
// - dual clock pointers cross domains through two synchroniser flip-flops
// - crossing pointers are gray coded, one bit changes per step
// - single clock variant uses binary pointers and no synchronisers
// - push side has own clock and active-low reset; pop side likewise
// - optional push clear resets push pointer and push flags; held one clock
// - optional pop clear resets pop pointer and pop flags; held one clock
// - push while full, pop while empty are refused and leave pointers, store and level flags unchanged
// - full flag on push side and empty flag on pop side always present
// - near-full flag high when exactly one more push makes it full
// - near-empty flag high when exactly one word remains
// - threshold limits: fixed single, input single, fixed range, input range
// - high-level flag sets at count >= assert limit, clears below negate
// - high-level range: assert is upper, negate lower, push address width
// - low-level flag sets at count <= limit, clears when count exceeds it
// - low-level range: assert is lower, negate upper, pop address width
// - handshake outputs report one clock later whether a request was taken
// - overflow pulses the cycle after a refused push
// - underflow pulses the cycle after a refused pop
// - pop acknowledge marks a valid word on the pop data output when fall-through is off
// - fill counts on each side, at that side's address width
// - fall-through mode shows the oldest word before any pop
// - threshold mode is const, dyn_single, range or dyn_range
// ***************************************************************
package dcf_pkg;

	// threshold selection, one per flag
	typedef enum logic [1:0] {
		DCF_TH_CONST      = 2'b00,
		DCF_TH_DYN_SINGLE = 2'b01,
		DCF_TH_RANGE      = 2'b10,
		DCF_TH_DYN_RANGE  = 2'b11
	} dcf_th_mode_t;

	// register byte offsets
	localparam logic [3:0]  DCF_OFS_CTRL   = 4'h0;
	localparam logic [3:0]  DCF_OFS_STAT   = 4'h4;
	// control fields
	localparam int          DCF_CTRL_PCLR  = 0;
	localparam int          DCF_CTRL_QCLR  = 1;
	localparam logic [1:0]  DCF_CTRL_RST   = 2'h0;
	// status fields
	localparam int          DCF_STAT_FULL  = 0;
	localparam int          DCF_STAT_AFULL = 1;
	localparam int          DCF_STAT_PFULL = 2;
	localparam int          DCF_STAT_CNT   = 16;
	localparam logic [31:0] DCF_RDATA_RST  = 32'h0000_0000;
	// bus answers one clock after a request is seen
	localparam int          DCF_BUS_WAIT   = 1;

endpackage : dcf_pkg

/* File: sim/dcf_agent.sv */
// producer and consumer model for the push and pop sides of the buffer
`timescale 1ns/1ps

module dcf_agent
#(
	parameter int WIDTH = 32
)
(
	// clock
	input  wire logic        clk_i,
	// producer
	output logic [WIDTH-1:0] push_data_o = '0,
	output logic             push_o = 1'b0,
	output logic             push_clr_o = 1'b0,
	// consumer
	output logic             pop_o = 1'b0,
	output logic             pop_clr_o = 1'b0
);
	// ****************************************
	// requests, one word per cycle
	// ****************************************
	task automatic push_n(input int n, input logic [WIDTH-1:0] base);
		for (int k = 0; k < n; k++)
		begin
			@(posedge clk_i);
			push_o      <= 1'b1;
			push_data_o <= base + WIDTH'(k);
		end
		@(posedge clk_i);
		push_o      <= 1'b0;
		// released data scrambled so a stale word never looks fresh
		push_data_o <= ~push_data_o;
	endtask

	task automatic pop_n(input int n);
		for (int k = 0; k < n; k++)
		begin
			@(posedge clk_i);
			pop_o <= 1'b1;
		end
		@(posedge clk_i);
		pop_o <= 1'b0;
	endtask

	// both clears held for exactly one clock
	task automatic clear();
		@(posedge clk_i);
		push_clr_o <= 1'b1;
		pop_clr_o  <= 1'b1;
		@(posedge clk_i);
		push_clr_o <= 1'b0;
		pop_clr_o  <= 1'b0;
	endtask
endmodule // dcf_agent

/* File: sim/dual_clock_fifo_with_flags_test.sv */
// self-checking bench for the buffer with flags and register bus
`timescale 1ns/1ps

module dual_clock_fifo_with_flags_test;
	import dcf_pkg::*;

	logic        clk_sys_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        rst_n = 1'b0;
	logic [31:0] push_data, qdata, q;
	logic        push, push_clr, pop, pop_clr;
	logic [3:0]  hi_a = 4'hC, hi_n = 4'hA, lo_t = 4'h3, tie0 = 4'h0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic        full, afull, pfull, pack, ovf, empty, aempty, pempty, qack, udf;
	logic [3:0]  pcnt, qcnt;
	int          num_errors = 0, compares = 0, cycles = 0;
	// flag order: full afull pfull pack ovf empty aempty pempty qack udf
	wire  [9:0]  flg = {full, afull, pfull, pack, ovf, empty, aempty, pempty, qack, udf};

	always #4 clk_sys_i = ~clk_sys_i;

	// negate 10 kept below assert 12 for the high-level flag
	dcf_fifo #(.DUAL_CLK(1'b0), .HI_MODE(DCF_TH_DYN_RANGE), .LO_MODE(DCF_TH_DYN_SINGLE)) dcf_fifo_i (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .push_rst_n_i(rst_n), .pop_clk_i(clk_sys_i),
		.pop_rst_n_i(rst_n), .push_data_i(push_data), .push_i(push), .push_clr_i(push_clr),
		.hi_thresh_i(tie0), .hi_assert_i(hi_a), .hi_negate_i(hi_n), .full_o(full),
		.almost_full_o(afull), .prog_full_o(pfull), .push_ack_o(pack), .overflow_o(ovf),
		.push_count_o(pcnt), .pop_i(pop), .pop_clr_i(pop_clr), .lo_thresh_i(lo_t),
		.lo_assert_i(tie0), .lo_negate_i(tie0), .pop_data_o(qdata), .empty_o(empty),
		.almost_empty_o(aempty), .prog_empty_o(pempty), .pop_ack_o(qack), .underflow_o(udf),
		.pop_count_o(qcnt), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));

	dcf_agent dcf_agent_i (.clk_i(clk_sys_i), .push_data_o(push_data), .push_o(push),
		.push_clr_o(push_clr), .pop_o(pop), .pop_clr_o(pop_clr));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic settle();
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask

	// request held until waitrequest is sampled low; only the bench timeout ends a stall
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		avs_read      <= ~wr;
		avs_write     <= wr;
		avs_address   <= a;
		avs_writedata <= d;
		do
		begin
			@(posedge clk_sys_i);
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic end_of_test();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk_sys_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			num_errors++;
			end_of_test();
		end
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		repeat (16) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		rst_n  <= 1'b1;
		#1;
		chk("reset flags", flg, 10'h014);
		chk("reset counts", {pcnt, qcnt}, 8'h00);
		dcf_agent_i.push_n(15, 32'h0);
		settle();
		chk("flags at 15", flg, 10'h180);
		chk("counts at 15", {pcnt, qcnt}, 8'hFF);
		dcf_agent_i.push_n(1, 32'hF);
		#1;
		chk("push ack", pack, 1'b1);
		settle();
		chk("flags full", flg, 10'h280);
		bus(1'b0, DCF_OFS_STAT, 32'h0);
		chk("stat full", q, 32'h0000_0005);
		dcf_agent_i.push_n(1, 32'h99);
		#1;
		chk("ack ovf", {pack, ovf}, 2'b01);
		settle();
		chk("flags refused", flg, 10'h280);
		for (int k = 0; k < 16; k++)
		begin
			dcf_agent_i.pop_n(1);
			#1;
			chk("pop data", qdata, 32'(k));
			chk("pop ack", qack, 1'b1);
			settle();
			chk("pop count", qcnt, 32'(15 - k));
			chk("prog full", pfull, (15 - k) >= 10);
			chk("prog empty", pempty, (15 - k) <= 3);
			chk("almost empty", aempty, (15 - k) == 1);
			chk("empty", empty, k == 15);
		end
		dcf_agent_i.pop_n(1);
		#1;
		chk("ack udf", {qack, udf}, 2'b01);
		settle();
		chk("flags underflow", flg, 10'h014);
		dcf_agent_i.push_n(11, 32'h100);
		settle();
		chk("prog full 11", pfull, 1'b0);
		dcf_agent_i.push_n(1, 32'h10B);
		settle();
		chk("prog full 12", pfull, 1'b1);
		dcf_agent_i.clear();
		settle();
		chk("pin clear", flg, 10'h014);
		chk("pin clear cnt", {pcnt, qcnt}, 8'h00);
		dcf_agent_i.push_n(2, 32'h0);
		bus(1'b1, DCF_OFS_CTRL, 32'h3);
		bus(1'b0, DCF_OFS_CTRL, 32'h0);
		chk("ctrl set", q, 32'h3);
		bus(1'b1, DCF_OFS_CTRL, 32'h0);
		settle();
		chk("reg clear", flg, 10'h014);
		bus(1'b0, DCF_OFS_CTRL, 32'h0);
		chk("ctrl read", q, 32'h0);
		bus(1'b1, 4'hC, 32'hFFFF_FFFF);
		bus(1'b0, 4'hC, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b0, DCF_OFS_STAT, 32'h0);
		chk("stat empty", q, 32'h0);
		// mid-run reset of both sides with words still stored
		dcf_agent_i.push_n(3, 32'h200);
		@(posedge clk_sys_i);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rst_n <= 1'b1;
		#1;
		chk("mid reset flags", flg, 10'h014);
		chk("mid reset counts", {pcnt, qcnt}, 8'h00);
		dcf_agent_i.push_n(1, 32'h300);
		dcf_agent_i.pop_n(1);
		#1;
		chk("after reset data", qdata, 32'h300);
		chk("after reset ack", qack, 1'b1);
		end_of_test();
	end
endmodule // dual_clock_fifo_with_flags_test
